// ### hw/rfm_params.svh
// Constants for the receive frame marker block: offsets, fields, resets.
// Assumes inclusion by the marker module; definitions only.
`ifndef RFM_PARAMS_SVH
`define RFM_PARAMS_SVH

// Register byte offsets
`define RFM_CTRL_OFS 8'h00
`define RFM_FRAME_OFS 8'h04
`define RFM_OH_OFS 8'h08
`define RFM_PLCP_OFS 8'h0c
`define RFM_STAT_OFS 8'h10

// Control field positions
`define RFM_MODE_LSB 0
`define RFM_MODE_MSB 2
`define RFM_PINS_EN_BIT 3
`define RFM_FS_EN_BIT 4
`define RFM_DE_EN_BIT 5
`define RFM_REF_LINE_BIT 6
`define RFM_REF_INV_BIT 7
`define RFM_FS_INV_BIT 8
`define RFM_DE_INV_BIT 9
`define RFM_POH_INV_BIT 10

// Reset values
`define RFM_CTRL_RST 16'h0000
`define RFM_FRAME_LEN_RST 16'h12a0
`define RFM_OH_PERIOD_RST 16'h0055
`define RFM_HDR_LEN_RST 16'h0000
`define RFM_POH_DIV_RST 16'h0040
`define RFM_POH_SEQ_RST 16'h0030

// Timing counts, in aclk cycles
`define RFM_CLK_HALF 16'h0002

// Bus answers
`define RFM_RESP_OKAY 2'h0
`define RFM_RESP_SLVERR 2'h2

`endif

// ### hw/rfm_pkg.sv
// Types for the receive frame marker block.
// Assumes nothing outside; constants live in rfm_params.svh.
package rfm_pkg;

    // Framer mode field of the control register
    typedef enum logic [2:0] {
        RFM_MODE_OFF = 3'b000,
        RFM_MODE_FRAMED = 3'b001,
        RFM_MODE_EXT_FRAC = 3'b010,
        RFM_MODE_FLEX_FRAC = 3'b011,
        RFM_MODE_INT_FRAC = 3'b100,
        RFM_MODE_PLCP = 3'b101
    } rfm_mode_t;

    // Function currently carried by the shared marker pin
    typedef enum logic [1:0] {
        RFM_FN_NONE = 2'b00,
        RFM_FN_FRAME_START = 2'b01,
        RFM_FN_PAYLOAD = 2'b10,
        RFM_FN_PLCP_START = 2'b11
    } rfm_fn_t;

    // Synchroniser state
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
        logic rise;
        logic fall;
    } rfm_sync_t;

    // Whole state of the marker block
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] ctrl;
        logic [15:0] frame_len;
        logic [15:0] oh_period;
        logic [15:0] hdr_len;
        logic [15:0] poh_div;
        logic [15:0] poh_seq;
        logic [15:0] clk_cnt;
        logic clk_out;
        logic [15:0] bit_cnt;
        logic [15:0] blk_cnt;
        logic [15:0] poh_cnt;
        logic poh_clk;
        logic [15:0] seq_cnt;
        logic poh_mark;
        logic marker;
        rfm_fn_t fn;
        logic [15:0] frames;
    } rfm_state_t;

endpackage

// ### hw/rfm_sync3.sv
// Three-stage synchroniser with edge pulses for an outside level.
// Assumes aclk is the sampling clock; input may change at any time.
`timescale 1ns/10ps

module rfm_sync3 (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Outside level
    input wire logic async_in,
    // Filtered level and edges, one-cycle pulses
    output logic level,
    output logic rise,
    output logic fall
);

    rfm_pkg::rfm_sync_t q, d;

    // Level only moves once stages two and three agree; ff1 feeds ff2 only
    always_comb begin
        d = q;
        d.ff1 = async_in;
        d.ff2 = q.ff1;
        d.ff3 = q.ff2;
        d.rise = 1'b0;
        d.fall = 1'b0;
        if (q.ff2 == q.ff3 && q.ff3 != q.level) begin
            d.level = q.ff3;
            d.rise = q.ff3;
            d.fall = !q.ff3;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign level = q.level;
    assign rise = q.rise;
    assign fall = q.fall;

endmodule

// ### hw/rfm_marker.sv
// Receive frame marker: shared frame-start / payload-enable / PLCP start
// pin with its framer and overhead clocks, configured over AXI4-Lite.
// Assumes aclk at 200 MHz, line clock arriving asynchronously.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "rfm_params.svh"

module rfm_marker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line side
    input wire logic rx_line_clock_in,
    output logic rx_framer_clock_out,
    output logic rx_plcp_overhead_clock,
    output logic rx_frame_marker
);

    rfm_pkg::rfm_state_t q, d;
    logic line_lvl;
    logic line_rise;
    logic line_fall;

    // Line clock comes from outside; sample it through three stages
    rfm_sync3 u_line_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(rx_line_clock_in),
        .level(line_lvl),
        .rise(line_rise),
        .fall(line_fall)
    );

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old,
            input logic [31:0] wd, input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) r[7:0] = wd[7:0];
        if (strb[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    // Counter step with wrap at a limit; a limit of zero wraps only at 16-bit overflow
    function automatic logic [15:0] step16(input logic [15:0] cnt,
            input logic [15:0] lim);
        logic [15:0] n;
        n = cnt + 16'h0001;
        if (lim != 16'h0000 && n >= lim) n = 16'h0000;
        return n;
    endfunction

    rfm_pkg::rfm_mode_t mode;
    logic pins_en;
    logic ref_tick;
    logic bit_oh;
    logic fs_ok;
    logic de_ok;
    logic plcp_ok;
    logic [31:0] rd_word;
    logic rd_err;

    // Decode of control fields and shared conditions
    always_comb begin
        mode = rfm_pkg::rfm_mode_t'(q.ctrl[`RFM_MODE_MSB:`RFM_MODE_LSB]);
        pins_en = q.ctrl[`RFM_PINS_EN_BIT];
        plcp_ok = (mode == rfm_pkg::RFM_MODE_PLCP) && pins_en;
        de_ok = (mode == rfm_pkg::RFM_MODE_EXT_FRAC
            || mode == rfm_pkg::RFM_MODE_FLEX_FRAC)
            && q.ctrl[`RFM_DE_EN_BIT] && pins_en;
        fs_ok = q.ctrl[`RFM_FS_EN_BIT]
            && (mode == rfm_pkg::RFM_MODE_EXT_FRAC
            || mode == rfm_pkg::RFM_MODE_FLEX_FRAC
            || (mode == rfm_pkg::RFM_MODE_FRAMED && pins_en));
        // Overhead bits: a header run at frame start, then one per block
        bit_oh = (q.bit_cnt < q.hdr_len)
            || (q.oh_period != 16'h0000 && q.blk_cnt == 16'h0000);
    end

    // Reference edge: which clock, and which of its edges
    always_comb begin
        if (q.ctrl[`RFM_REF_LINE_BIT]) begin
            ref_tick = q.ctrl[`RFM_REF_INV_BIT] ? line_fall : line_rise;
        end else begin
            ref_tick = q.ctrl[`RFM_REF_INV_BIT]
                ? (q.clk_cnt == 16'h0000 && q.clk_out)
                : (q.clk_cnt == 16'h0000 && !q.clk_out);
        end
    end

    // Read decode; reserved bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_axi_araddr == `RFM_CTRL_OFS) begin
            rd_word[15:0] = q.ctrl;
        end else if (s_axi_araddr == `RFM_FRAME_OFS) begin
            rd_word[15:0] = q.frame_len;
        end else if (s_axi_araddr == `RFM_OH_OFS) begin
            rd_word = {q.hdr_len, q.oh_period};
        end else if (s_axi_araddr == `RFM_PLCP_OFS) begin
            rd_word = {q.poh_seq, q.poh_div};
        end else if (s_axi_araddr == `RFM_STAT_OFS) begin
            rd_word = {q.frames, 12'h000, line_lvl, q.marker, q.fn};
        end else begin
            rd_err = 1'b1;
        end
    end

    // Next state of the whole block
    always_comb begin
        d = q;
        // Write address and data are taken in either order
        if (s_axi_awvalid && q.awready) begin
            d.aw_got = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.wready) begin
            d.w_got = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `RFM_RESP_OKAY;
            if (q.aw_addr == `RFM_CTRL_OFS) begin
                d.ctrl = merge16(q.ctrl, q.w_data, q.w_strb);
            end else if (q.aw_addr == `RFM_FRAME_OFS) begin
                d.frame_len = merge16(q.frame_len, q.w_data, q.w_strb);
            end else if (q.aw_addr == `RFM_OH_OFS) begin
                d.oh_period = merge16(q.oh_period, q.w_data, q.w_strb);
                d.hdr_len = merge16(q.hdr_len, q.w_data >> 16,
                    q.w_strb >> 2);
            end else if (q.aw_addr == `RFM_PLCP_OFS) begin
                d.poh_div = merge16(q.poh_div, q.w_data, q.w_strb);
                d.poh_seq = merge16(q.poh_seq, q.w_data >> 16,
                    q.w_strb >> 2);
            end else if (q.aw_addr != `RFM_STAT_OFS) begin
                d.bresp = `RFM_RESP_SLVERR; // Unmapped; status writes stay OKAY
            end
        end
        d.awready = !d.aw_got && !d.bvalid;
        d.wready = !d.w_got && !d.bvalid;

        // Read: one outstanding, answer one cycle after acceptance
        if (s_axi_rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && q.arready) begin
            d.rvalid = 1'b1;
            d.rdata = rd_word;
            d.rresp = rd_err ? `RFM_RESP_SLVERR : `RFM_RESP_OKAY;
        end
        d.arready = !d.rvalid;

        // Internal framer clock divided from aclk, driven straight out
        if (q.clk_cnt == 16'h0000) begin
            d.clk_cnt = `RFM_CLK_HALF - 16'h0001;
            d.clk_out = !q.clk_out;
        end else begin
            d.clk_cnt = q.clk_cnt - 16'h0001;
        end

        // Bit position advances once per reference edge
        if (ref_tick) begin
            d.bit_cnt = step16(q.bit_cnt, q.frame_len);
            d.blk_cnt = (d.bit_cnt == 16'h0000) ? 16'h0000
                : step16(q.blk_cnt, q.oh_period);
            if (d.bit_cnt == 16'h0000) begin
                d.frames = q.frames + 16'h0001;
            end
            // Overhead clock runs slow, derived from framer bits
            d.poh_cnt = step16(q.poh_cnt, q.poh_div);
            if (d.poh_cnt == 16'h0000) begin
                d.poh_clk = !q.poh_clk;
                if (q.poh_clk) begin
                    // Marker moves with the falling overhead clock
                    d.seq_cnt = step16(q.seq_cnt, q.poh_seq);
                    d.poh_mark = (d.seq_cnt == 16'h0000);
                end
            end
        end

        // One function at most; PLCP first, then payload, then frame start
        if (plcp_ok) begin
            d.fn = rfm_pkg::RFM_FN_PLCP_START;
            d.marker = d.poh_mark ^ q.ctrl[`RFM_POH_INV_BIT];
        end else if (de_ok) begin
            d.fn = rfm_pkg::RFM_FN_PAYLOAD;
            if (ref_tick) begin
                d.marker = !((d.bit_cnt < q.hdr_len)
                    || (q.oh_period != 16'h0000 && d.blk_cnt == 16'h0000))
                    ^ q.ctrl[`RFM_DE_INV_BIT];
            end else begin
                d.marker = !bit_oh ^ q.ctrl[`RFM_DE_INV_BIT];
            end
        end else if (fs_ok) begin
            d.fn = rfm_pkg::RFM_FN_FRAME_START;
            d.marker = ((ref_tick ? d.bit_cnt : q.bit_cnt) == 16'h0000)
                ^ q.ctrl[`RFM_FS_INV_BIT];
        end else begin
            d.fn = rfm_pkg::RFM_FN_NONE;
            d.marker = 1'b0;
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.ctrl <= `RFM_CTRL_RST;
            q.frame_len <= `RFM_FRAME_LEN_RST;
            q.oh_period <= `RFM_OH_PERIOD_RST;
            q.hdr_len <= `RFM_HDR_LEN_RST;
            q.poh_div <= `RFM_POH_DIV_RST;
            q.poh_seq <= `RFM_POH_SEQ_RST;
        end else begin
            q <= d;
        end
    end

    // All outputs come straight from the state register
    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign rx_framer_clock_out = q.clk_out;
    assign rx_plcp_overhead_clock = q.poh_clk;
    assign rx_frame_marker = q.marker;

endmodule

// ### testbench/rfm_far_end.sv
// Far-side logic model: makes the line clock, takes the overhead port.
// Assumes the overhead clock and marker come straight from the block.
`timescale 1ns/10ps

module rfm_far_end (
    // Line clock towards the block
    output logic rx_line_clock_in,
    // Overhead port from the block
    input wire logic rx_plcp_overhead_clock,
    input wire logic rx_frame_marker,
    // Sequence starts seen so far
    output logic [15:0] poh_marks
);
    // A recovered line clock never pauses, so it runs free here
    initial begin
        rx_line_clock_in = 1'b0;
        forever #24 rx_line_clock_in = ~rx_line_clock_in;
    end

    // Start marker is taken on the overhead clock rise, half a period
    // after the block moved it
    initial poh_marks = 16'h0000;
    always @(posedge rx_plcp_overhead_clock) begin
        if (rx_frame_marker === 1'b1) begin
            poh_marks <= poh_marks + 16'h0001;
        end
    end
endmodule

// ### testbench/rfm_marker_props.sv
// Port checker for the receive frame marker, bound to its top module.
// Assumes bus masters offer write address and data in the same cycle.
`timescale 1ns/10ps

module rfm_marker_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line side
    input wire logic rx_framer_clock_out,
    input wire logic rx_frame_marker
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic line_ref_q;
    logic ctrl_set_q;
    logic [3:0] quiet_q;
    logic aw_hit;
    logic both_hit;
    assign aw_hit = s_axi_awvalid && s_axi_awready;
    assign both_hit = aw_hit && s_axi_wvalid && s_axi_wready;

    // Shadow of the reference choice; marker checks rest for a while
    // after any write, since a new setting may move the pin at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_ref_q <= 1'b0;
            ctrl_set_q <= 1'b0;
            quiet_q <= 4'h0;
        end else begin
            if (aw_hit) quiet_q <= 4'hf;
            else if (quiet_q != 4'h0) quiet_q <= quiet_q - 4'h1;
            if (both_hit && s_axi_awaddr == 8'h00) begin
                line_ref_q <= s_axi_wdata[6];
                ctrl_set_q <= s_axi_wdata[15:0] != 16'h0000;
            end
        end
    end

    chk_fclk_half: assert property ($changed(rx_framer_clock_out)
        |=> $stable(rx_framer_clock_out))
        else $error("framer clock half short");
    chk_marker_ref: assert property ($changed(rx_frame_marker) &&
        !line_ref_q && quiet_q == 4'h0 |-> $changed(rx_framer_clock_out))
        else $error("marker moved off the reference edge");
    chk_marker_idle: assert property (!ctrl_set_q && quiet_q == 4'h0
        |-> !rx_frame_marker) else $error("marker active with no function");
    chk_aw_taken: assert property (aw_hit |=> !s_axi_awready)
        else $error("awready stayed high after taking");
    chk_write_ans: assert property (both_hit |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    chk_read_ans: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rvalid dropped");
    chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr > 8'h10 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_wr_unmapped: assert property (both_hit && s_axi_awaddr > 8'h10
        |=> ##1 s_axi_bresp == 2'h2) else $error("unmapped write not refused");
endmodule

bind rfm_marker rfm_marker_props rfm_marker_props_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .rx_framer_clock_out(rx_framer_clock_out),
    .rx_frame_marker(rx_frame_marker));

// ### testbench/rfm_marker_tb.sv
// Self-checking bench for the receive frame marker over its register bus.
// Assumes a 16-bit frame, two header overhead bits, overhead clock /4 by 3.
`timescale 1ns/10ps

module rfm_marker_tb;
    logic aclk;
    logic aresetn;
    logic [7:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [7:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    logic rx_line_clock_in;
    logic rx_framer_clock_out;
    logic rx_plcp_overhead_clock;
    logic rx_frame_marker;
    logic [15:0] poh_marks;
    logic [15:0] poh_delta;
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;

    rfm_marker rfm_marker_inst (.*);
    rfm_far_end rfm_far_end_inst (.rx_line_clock_in(rx_line_clock_in),
        .rx_plcp_overhead_clock(rx_plcp_overhead_clock),
        .rx_frame_marker(rx_frame_marker), .poh_marks(poh_marks));

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Whole run needs about 18k cycles; a hang ends well past that
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) wd = 1'b1;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    // Counting over 960 cycles spans whole frames and sequences on the internal
    // framer clock, so there the count is independent of where the window starts
    task automatic meas(input logic [15:0] c, input int lo, input int hi,
                        input string nm);
        int n;
        logic [15:0] p0;
        n = 0;
        wr(8'h00, {16'h0000, c}, 4'hf, 2'h0);
        repeat (100) @(posedge aclk);
        p0 = poh_marks;
        repeat (960) begin
            @(posedge aclk);
            if (rx_frame_marker === 1'b1) n++;
        end
        poh_delta = poh_marks - p0;
        chk(nm, {31'h0, (n >= lo && n <= hi)}, 32'h1);
        $display("test %s done, high cycles %0d", nm, n);
    endtask

    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values, refusals, byte lanes
        rd(8'h00, 32'h0000_0000, 2'h0);
        rd(8'h04, 32'h0000_12a0, 2'h0);
        rd(8'h08, 32'h0000_0055, 2'h0);
        rd(8'h0c, 32'h0030_0040, 2'h0);
        rd(8'h14, 32'h0000_0000, 2'h2);
        wr(8'h14, 32'h0000_ffff, 4'hf, 2'h2);
        wr(8'h10, 32'hffff_ffff, 4'hf, 2'h0);
        wr(8'h04, 32'hffff_ff10, 4'h1, 2'h0);
        rd(8'h04, 32'h0000_1210, 2'h0);
        wr(8'h04, 32'h0000_0010, 4'hf, 2'h0);
        wr(8'h08, 32'h0002_0000, 4'hf, 2'h0);
        wr(8'h0c, 32'h0003_0002, 4'hf, 2'h0);
        rd(8'h0c, 32'h0003_0002, 2'h0);
        $display("test registers done");
        // Pin functions per mode and enable
        meas(16'h0011, 0, 0, "fs_nopins");
        meas(16'h0019, 60, 60, "fs_framed");
        meas(16'h0012, 60, 60, "fs_extfrac");
        meas(16'h0119, 900, 900, "fs_inv");
        meas(16'h0099, 60, 60, "fs_refinv");
        meas(16'h0059, 50, 72, "fs_lineref");
        meas(16'h00d9, 50, 72, "fs_lineinv");
        meas(16'h002a, 840, 840, "de_extfrac");
        meas(16'h022b, 120, 120, "de_flex_inv");
        meas(16'h0022, 0, 0, "de_nopins");
        meas(16'h002c, 0, 0, "de_intfrac");
        meas(16'h003a, 840, 840, "fs_and_de");
        // Block overhead every fourth bit: bits 0,1,4,8,12 are overhead
        wr(8'h08, 32'h0002_0004, 4'hf, 2'h0);
        meas(16'h002a, 660, 660, "de_blocks");
        meas(16'h0005, 0, 0, "plcp_nopins");
        meas(16'h040d, 640, 640, "plcp_inv");
        meas(16'h000d, 320, 320, "plcp");
        chk("poh_marks", {16'h0000, poh_delta}, 32'h0000_0014);
        meas(16'h0000, 0, 0, "off");
        conclude();
    end
endmodule
